// ### hw/op_timing_engine.sv
// op_timing_engine: runs one timed instruction form to completion
// assumes issue from same-clock logic; bus ack arrives from a pin
`timescale 1ns/1ps
module op_timing_engine (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // issue port
  input  wire timing_pkg::issue_t    issue_i,
  output logic                       busy_o,
  output logic                       done_o,
  output timing_pkg::report_t        report_o,
  // processor bus
  input  wire logic                  bus_ack_i,
  output logic                       bus_req_o,
  output timing_pkg::bus_kind_t      bus_kind_o
);
  import timing_pkg::*;

  typedef enum logic {st_idle, st_run} st_t;

  st_t        state_ff, nxt_state;
  logic       done_ff, nxt_done;
  report_t    report_ff, nxt_report;
  report_t    table_report;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [1:0] rd_left_ff, nxt_rd_left;
  logic       pf_left_ff, nxt_pf_left;
  logic       wr_left_ff, nxt_wr_left;
  logic [7:0] elapsed_ff, nxt_elapsed;
  logic       take;
  logic       launch;
  bus_kind_t  launch_kind;
  logic       hs_idle;
  logic       bus_done;
  logic       time_up;

  // tabulated timing of the requested form
  form_timing_rom u_rom (
    .form_i   (issue_i.form),
    .speed_i  (issue_i.speed),
    .report_o (table_report)
  );

  // one bus cycle at a time toward memory
  bus_handshake u_hs (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .launch_i (launch),
    .kind_i   (launch_kind),
    .idle_o   (hs_idle),
    .ack_i    (bus_ack_i),
    .req_o    (bus_req_o),
    .kind_o   (bus_kind_o)
  );

  // a request is taken only while idle; shift amount is not looked at
  assign take     = issue_i.valid && (state_ff == st_idle); // [RQ11]
  assign time_up  = (cnt_ff == CNT_LAST);
  assign bus_done = hs_idle && (rd_left_ff == 2'h0) && !pf_left_ff && !wr_left_ff;

  // launch order: reads, then prefetch, then write
  always_comb begin
    launch      = 1'h0;
    launch_kind = bus_read;
    if (state_ff == st_run && hs_idle) begin
      if (rd_left_ff != 2'h0) begin
        launch      = 1'h1; // [RQ1]
        launch_kind = bus_read;
      end else if (pf_left_ff) begin
        launch      = 1'h1; // [RQ1]
        launch_kind = bus_prefetch;
      end else if (wr_left_ff) begin
        launch      = 1'h1; // [RQ1]
        launch_kind = bus_write;
      end
    end
  end

  // outstanding bus cycle counts
  always_comb begin
    nxt_rd_left = rd_left_ff;
    nxt_pf_left = pf_left_ff;
    nxt_wr_left = wr_left_ff;
    if (take) begin
      nxt_rd_left = table_report.reads;
      nxt_pf_left = table_report.prefetch;
      nxt_wr_left = table_report.writes;
    end else if (launch) begin
      case (launch_kind)
        bus_read:     nxt_rd_left = rd_left_ff - 2'h1;
        bus_prefetch: nxt_pf_left = 1'h0;
        bus_write:    nxt_wr_left = 1'h0;
        default:      nxt_rd_left = rd_left_ff;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_left_ff <= 2'h0;
      pf_left_ff <= 1'h0;
      wr_left_ff <= 1'h0;
    end else begin
      rd_left_ff <= nxt_rd_left;
      pf_left_ff <= nxt_pf_left;
      wr_left_ff <= nxt_wr_left;
    end
  end

  // clock count down to the last tabulated clock
  always_comb begin
    nxt_cnt = cnt_ff;
    if (take) begin
      nxt_cnt = table_report.total; // [RQ1]
    end else if (state_ff == st_run && !time_up) begin
      nxt_cnt = cnt_ff - 5'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_ff <= CNT_LAST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // sequence: run until time is up and memory has finished
  always_comb begin
    nxt_state  = state_ff;
    nxt_done   = 1'h0;
    nxt_report = report_ff;
    case (state_ff)
      st_idle: if (take) begin
        nxt_state  = st_run;
        nxt_report = table_report; // [RQ1]
      end
      st_run: if (time_up && bus_done) begin
        nxt_state = st_idle; // [RQ20]
        nxt_done  = 1'h1;
      end
      default: nxt_state = st_idle;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff  <= st_idle;
      done_ff   <= 1'h0;
      report_ff <= REPORT_RST;
    end else begin
      state_ff  <= nxt_state;
      done_ff   <= nxt_done;
      report_ff <= nxt_report;
    end
  end

  // clocks since the request was taken
  always_comb begin
    nxt_elapsed = elapsed_ff;
    if (take) begin
      nxt_elapsed = ELAPSED_RST;
    end else if (state_ff == st_run) begin
      nxt_elapsed = elapsed_ff + 8'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      elapsed_ff <= ELAPSED_RST;
    end else begin
      elapsed_ff <= nxt_elapsed;
    end
  end

  // outputs from flops
  assign busy_o   = (state_ff == st_run);
  assign done_o   = done_ff;
  assign report_o = report_ff;

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  property p_prefetch_worst;
    take |=> (report_ff.prefetch == ($past(issue_i.speed) == case_worst));
  endproperty
  a_prefetch_worst: assert property (p_prefetch_worst) // [RQ1]
    else $error("prefetch count not tied to worst case");

  property p_write_after_reads;
    $rose(bus_req_o) && bus_kind_o == bus_write |-> rd_left_ff == 2'h0 && !pf_left_ff;
  endproperty
  a_write_after_reads: assert property (p_write_after_reads) // [RQ1]
    else $error("write issued before reads or prefetch");

  property p_no_ea_decimal;
    take && (issue_i.form == memory_compare_postincrement ||
             issue_i.form == decimal_expand_mem) |=> report_ff.ea_add == ea_none;
  endproperty
  a_no_ea_decimal: assert property (p_no_ea_decimal) // [RQ2]
    else $error("decimal form reports address time");

  property p_decimal_mem;
    take && issue_i.form == decimal_subtract_with_extend_mem && issue_i.speed == case_cache
      |=> report_ff.total == DEC_MEM_CLK.cache && report_ff.reads == RD_TWO && report_ff.writes;
  endproperty
  a_decimal_mem: assert property (p_decimal_mem) // [RQ3]
    else $error("decimal memory timing wrong");

  property p_binary_mem;
    take && issue_i.form == binary_add_with_extend_mem && issue_i.speed == case_worst
      |=> report_ff.total == BIN_MEM_CLK.worst && report_ff.prefetch && report_ff.writes;
  endproperty
  a_binary_mem: assert property (p_binary_mem) // [RQ4]
    else $error("binary memory timing wrong");

  property p_compress_mem;
    take && issue_i.form == decimal_compress_mem && issue_i.speed == case_best
      |=> report_ff.total == DECIMAL_COMPRESS_MEM_CLK.best && report_ff.reads == RD_ONE;
  endproperty
  a_compress_mem: assert property (p_compress_mem) // [RQ5]
    else $error("compress memory timing wrong");

  property p_decimal_reg;
    take && issue_i.form == decimal_add_with_extend_reg && issue_i.speed == case_best
      |=> !bus_req_o [*4] ##1 done_o;
  endproperty
  a_decimal_reg: assert property (p_decimal_reg) // [RQ6]
    else $error("decimal register form not done in four clocks");

  property p_tas_mem;
    take && issue_i.form == test_then_set_operand_mem
      |=> report_ff.total >= TAS_MEM_CLK.best && report_ff.reads == RD_ONE
          && report_ff.writes && report_ff.ea_add == ea_calc;
  endproperty
  a_tas_mem: assert property (p_tas_mem) // [RQ7]
    else $error("test-then-set timing wrong");

  property p_zero_mem;
    take && issue_i.form == operand_zeroing_mem
      |=> report_ff.reads == 2'h0 && report_ff.writes && report_ff.ea_add == ea_calc;
  endproperty
  a_zero_mem: assert property (p_zero_mem) // [RQ8]
    else $error("zeroing must write once and never read");

  property p_cond_set;
    take && issue_i.form == condition_set_mem |=> report_ff.total == CSET_MEM_CLK.worst;
  endproperty
  a_cond_set: assert property (p_cond_set) // [RQ9]
    else $error("condition set not six clocks");

  property p_ea_fetch;
    take && (issue_i.form == rotate_leftward_mem || issue_i.form == single_bit_set_mem_reg)
      |=> report_ff.ea_add == ea_fetch;
  endproperty
  a_ea_fetch: assert property (p_ea_fetch) // [RQ10]
    else $error("fetched address time missing");

  property p_exact_time;
    done_o && report_ff.reads == 2'h0 && !report_ff.prefetch && !report_ff.writes
      |-> elapsed_ff == {3'h0, report_ff.total};
  endproperty
  a_exact_time: assert property (p_exact_time) // [RQ11]
    else $error("busless form did not finish on its count");

  property p_shift_dyn;
    take && issue_i.form == logical_shift_rightward_dynamic && issue_i.speed == case_best
      |=> ##3 done_o;
  endproperty
  a_shift_dyn: assert property (p_shift_dyn) // [RQ12]
    else $error("dynamic shift not three clocks");

  property p_rox_reg;
    take && issue_i.form == rotate_through_extend_leftward_reg && issue_i.speed == case_cache
      |=> report_ff.total == ROX_REG_CLK.cache && report_ff.writes == 1'h0;
  endproperty
  a_rox_reg: assert property (p_rox_reg) // [RQ13]
    else $error("rotate through extend timing wrong");

  property p_rot_mem;
    take && issue_i.form == rotate_rightward_mem
      |=> report_ff.total == ROT_MEM_CLK.best && report_ff.writes;
  endproperty
  a_rot_mem: assert property (p_rot_mem) // [RQ14]
    else $error("rotate memory timing wrong");

  property p_bit_reg;
    take && issue_i.form == single_bit_toggle_reg && issue_i.speed == case_best |=> ##1 done_o;
  endproperty
  a_bit_reg: assert property (p_bit_reg) // [RQ15]
    else $error("bit register op not one clock");

  property p_bit_test_mem;
    take && issue_i.form == single_bit_test_mem_reg
      |=> report_ff.reads == 2'h0 && !report_ff.writes && report_ff.total >= BIT_MEM_CLK.best;
  endproperty
  a_bit_test_mem: assert property (p_bit_test_mem) // [RQ16]
    else $error("bit test memory has operand cycles");

  property p_bit_mod_imm;
    take && issue_i.form == single_bit_clear_mem_imm
      |=> report_ff.writes && report_ff.ea_add == ea_fetch_imm; // [RQ17]
  endproperty
  a_bit_mod_imm: assert property (p_bit_mod_imm) // [RQ18]
    else $error("immediate bit op lacks immediate address time");

  property p_not_early;
    done_o |-> elapsed_ff >= {3'h0, report_ff.total} && !bus_req_o && bus_done;
  endproperty
  a_not_early: assert property (p_not_early) // [RQ20]
    else $error("finished before count or bus cycles");

  property p_req_busy;
    $rose(bus_req_o) |-> busy_o;
  endproperty
  a_req_busy: assert property (p_req_busy) // [RQ20]
    else $error("bus cycle started while idle");

  // main scenarios
  c_busless: cover property (take ##1 busy_o [*3] ##1 done_o);
  c_mem_write: cover property ($rose(bus_req_o) && bus_kind_o == bus_write);
  c_two_reads: cover property (take && issue_i.form == decimal_add_with_extend_mem
                               && issue_i.speed == case_worst);
  c_back_to_back: cover property (done_o && take);
endmodule

// ### hw/timing_pkg.sv
// timing package: instruction forms, reports, tabulated clock counts
// assumes one processor clock; memory answers bus cycles by handshake
// Contract
// (RQ1) total includes bus cycles; report read/prefetch/write
// (RQ2) decimal/extended forms add no address time
// (RQ3) decimal memory forms: 14/16/17, 2 reads, 1 write
// (RQ4) binary extended memory forms: 10/12/13, 2r/1w
// (RQ5) compress/expand memory: 11/13/13, 1r/1w
// (RQ6) decimal register forms: 4/4/5, no operand cycles
// (RQ7) test-then-set memory: 12/12/13, read then write
// (RQ8) zeroing memory: 3/4/6, one write only
// (RQ9) condition set memory: 6 always, one write
// (RQ10) calculated or fetched address time per form
// (RQ11) shift amount never changes clock count
// (RQ12) logical shifts: static 1/4/4, dynamic 3/6/6
// (RQ13) rotate through extend register: 9/12/12
// (RQ14) rotate memory by one: 7 always, one write
// (RQ15) bit ops on register: 1/4/5
// (RQ16) bit test memory: 4/4/5, no operand cycles
// (RQ17) bit modify memory: 4/4/5, one write
// (RQ18) immediate bit number adds immediate address time
// (RQ19) best overlaps, cache hits, worst neither
// (RQ20) memory completes bus cycles before finish
package timing_pkg;
  typedef enum logic [1:0] {case_best, case_cache, case_worst} speed_t;
  typedef enum logic [1:0] {ea_none, ea_fetch, ea_calc, ea_fetch_imm} ea_add_t;
  typedef enum logic [1:0] {bus_read, bus_prefetch, bus_write} bus_kind_t;
  typedef enum logic [5:0] {
    decimal_add_with_extend_reg, decimal_add_with_extend_mem,
    decimal_subtract_with_extend_reg, decimal_subtract_with_extend_mem,
    binary_add_with_extend_reg, binary_add_with_extend_mem,
    binary_subtract_with_extend_reg, binary_subtract_with_extend_mem,
    memory_compare_postincrement, decimal_compress_reg, decimal_compress_mem,
    decimal_expand_reg, decimal_expand_mem, operand_zeroing_mem,
    condition_set_mem, test_then_set_operand_mem,
    logical_shift_leftward_static, logical_shift_rightward_static,
    logical_shift_leftward_dynamic, logical_shift_rightward_dynamic,
    rotate_through_extend_leftward_reg, rotate_through_extend_rightward_reg,
    rotate_leftward_mem, rotate_rightward_mem,
    single_bit_test_reg, single_bit_toggle_reg, single_bit_clear_reg,
    single_bit_set_reg, single_bit_test_mem_imm, single_bit_test_mem_reg,
    single_bit_toggle_mem_imm, single_bit_toggle_mem_reg,
    single_bit_clear_mem_imm, single_bit_clear_mem_reg,
    single_bit_set_mem_imm, single_bit_set_mem_reg
  } form_t;
  typedef struct packed {
    logic [4:0] best;
    logic [4:0] cache;
    logic [4:0] worst;
  } clk3_t;
  typedef struct packed {
    logic       valid;
    form_t      form;
    speed_t     speed;
    logic [5:0] shift_amt;
  } issue_t;
  typedef struct packed {
    logic [4:0] total;
    logic [1:0] reads;
    logic       prefetch;
    logic       writes;
    ea_add_t    ea_add;
  } report_t;
  localparam clk3_t DEC_REG_CLK  = '{5'h04, 5'h04, 5'h05};
  localparam clk3_t DEC_MEM_CLK  = '{5'h0e, 5'h10, 5'h11};
  localparam clk3_t BIN_REG_CLK  = '{5'h02, 5'h02, 5'h03};
  localparam clk3_t BIN_MEM_CLK  = '{5'h0a, 5'h0c, 5'h0d};
  localparam clk3_t CMP_MEM_CLK  = '{5'h08, 5'h09, 5'h0a};
  localparam clk3_t CMPR_REG_CLK = '{5'h03, 5'h06, 5'h07};
  localparam clk3_t EXPD_REG_CLK = '{5'h05, 5'h08, 5'h09};
  localparam clk3_t DECIMAL_COMPRESS_MEM_CLK = '{5'h0b, 5'h0d, 5'h0d};
  localparam clk3_t ZERO_MEM_CLK = '{5'h03, 5'h04, 5'h06};
  localparam clk3_t CSET_MEM_CLK = '{5'h06, 5'h06, 5'h06};
  localparam clk3_t TAS_MEM_CLK  = '{5'h0c, 5'h0c, 5'h0d};
  localparam clk3_t SHS_CLK      = '{5'h01, 5'h04, 5'h04};
  localparam clk3_t SHD_CLK      = '{5'h03, 5'h06, 5'h06};
  localparam clk3_t ROX_REG_CLK  = '{5'h09, 5'h0c, 5'h0c};
  localparam clk3_t ROT_MEM_CLK  = '{5'h07, 5'h07, 5'h07};
  localparam clk3_t BIT_REG_CLK  = '{5'h01, 5'h04, 5'h05};
  localparam clk3_t BIT_MEM_CLK  = '{5'h04, 5'h04, 5'h05};
  localparam logic [1:0] RD_ONE     = 2'h1;
  localparam logic [1:0] RD_TWO     = 2'h2;
  localparam report_t    REPORT_RST = '0;
  localparam logic [4:0] CNT_LAST   = 5'h01;
  localparam logic [7:0] ELAPSED_RST = 8'h00;
endpackage

// ### hw/form_timing_rom.sv
// form_timing_rom: maps a form and speed case to its timing report
// assumes a legal form code; unknown codes report zero
`timescale 1ns/1ps
module form_timing_rom (
  // request
  input  wire timing_pkg::form_t   form_i,
  input  wire timing_pkg::speed_t  speed_i,
  // answer
  output timing_pkg::report_t      report_o
);
  import timing_pkg::*;

  // choose the column for the speed case
  function automatic logic [4:0] pick(clk3_t c, speed_t s);
    case (s)
      case_best:  return c.best;  // [RQ19]
      case_cache: return c.cache; // [RQ19]
      default:    return c.worst; // [RQ19]
    endcase
  endfunction

  // table lookup; prefetch only in the worst case
  always_comb begin
    report_o          = REPORT_RST;
    report_o.prefetch = (speed_i == case_worst); // [RQ1]
    case (form_i)
      decimal_add_with_extend_reg, decimal_subtract_with_extend_reg:
        report_o.total = pick(DEC_REG_CLK, speed_i); // [RQ6] [RQ2]
      decimal_add_with_extend_mem, decimal_subtract_with_extend_mem: begin
        report_o.total  = pick(DEC_MEM_CLK, speed_i); // [RQ3]
        report_o.reads  = RD_TWO;
        report_o.writes = 1'h1;
      end
      binary_add_with_extend_reg, binary_subtract_with_extend_reg:
        report_o.total = pick(BIN_REG_CLK, speed_i);
      binary_add_with_extend_mem, binary_subtract_with_extend_mem: begin
        report_o.total  = pick(BIN_MEM_CLK, speed_i); // [RQ4]
        report_o.reads  = RD_TWO;
        report_o.writes = 1'h1;
      end
      memory_compare_postincrement: begin
        report_o.total = pick(CMP_MEM_CLK, speed_i); // [RQ2]
        report_o.reads = RD_TWO;
      end
      decimal_compress_reg: report_o.total = pick(CMPR_REG_CLK, speed_i);
      decimal_expand_reg:   report_o.total = pick(EXPD_REG_CLK, speed_i);
      decimal_compress_mem, decimal_expand_mem: begin
        report_o.total  = pick(DECIMAL_COMPRESS_MEM_CLK, speed_i); // [RQ5]
        report_o.reads  = RD_ONE;
        report_o.writes = 1'h1;
      end
      operand_zeroing_mem, condition_set_mem, test_then_set_operand_mem: begin
        report_o.total  = (form_i == operand_zeroing_mem) ? pick(ZERO_MEM_CLK, speed_i) : // [RQ8]
                          (form_i == condition_set_mem) ? pick(CSET_MEM_CLK, speed_i) : // [RQ9]
                          pick(TAS_MEM_CLK, speed_i); // [RQ7]
        report_o.reads  = (form_i == test_then_set_operand_mem) ? RD_ONE : 2'h0;
        report_o.writes = 1'h1;
        report_o.ea_add = ea_calc; // [RQ10]
      end
      logical_shift_leftward_static, logical_shift_rightward_static:
        report_o.total = pick(SHS_CLK, speed_i); // [RQ12]
      logical_shift_leftward_dynamic, logical_shift_rightward_dynamic:
        report_o.total = pick(SHD_CLK, speed_i); // [RQ12]
      rotate_through_extend_leftward_reg, rotate_through_extend_rightward_reg:
        report_o.total = pick(ROX_REG_CLK, speed_i); // [RQ13]
      rotate_leftward_mem, rotate_rightward_mem: begin
        report_o.total  = pick(ROT_MEM_CLK, speed_i); // [RQ14]
        report_o.writes = 1'h1;
        report_o.ea_add = ea_fetch; // [RQ10]
      end
      single_bit_test_reg, single_bit_toggle_reg, single_bit_clear_reg, single_bit_set_reg:
        report_o.total = pick(BIT_REG_CLK, speed_i); // [RQ15]
      single_bit_test_mem_imm, single_bit_test_mem_reg: begin
        report_o.total  = pick(BIT_MEM_CLK, speed_i); // [RQ16]
        report_o.ea_add = (form_i == single_bit_test_mem_imm) ? ea_fetch_imm : ea_fetch; // [RQ18]
      end
      single_bit_toggle_mem_imm, single_bit_clear_mem_imm, single_bit_set_mem_imm: begin
        report_o.total  = pick(BIT_MEM_CLK, speed_i); // [RQ17]
        report_o.writes = 1'h1;
        report_o.ea_add = ea_fetch_imm; // [RQ18]
      end
      single_bit_toggle_mem_reg, single_bit_clear_mem_reg, single_bit_set_mem_reg: begin
        report_o.total  = pick(BIT_MEM_CLK, speed_i); // [RQ17]
        report_o.writes = 1'h1;
        report_o.ea_add = ea_fetch; // [RQ10]
      end
      default: report_o = REPORT_RST;
    endcase
  end
endmodule

// ### hw/bus_handshake.sv
// bus_handshake: four-phase request/acknowledge for one bus cycle
// assumes memory raises ack after req and drops it after req falls
`timescale 1ns/1ps
module bus_handshake (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // launch side
  input  wire logic                  launch_i,
  input  wire timing_pkg::bus_kind_t kind_i,
  output logic                       idle_o,
  // memory side
  input  wire logic                  ack_i,
  output logic                       req_o,
  output timing_pkg::bus_kind_t      kind_o
);
  import timing_pkg::*;
  typedef enum logic [1:0] {hs_idle, hs_req, hs_rel} hs_state_t;
  hs_state_t state_ff, nxt_state;
  logic      ack_s1_ff, ack_s2_ff;
  logic      req_ff, nxt_req;
  bus_kind_t kind_ff, nxt_kind;

  // next phase of the handshake
  always_comb begin
    nxt_state = state_ff;
    nxt_kind  = kind_ff;
    case (state_ff)
      hs_idle: if (launch_i) begin
        nxt_state = hs_req;
        nxt_kind  = kind_i;
      end
      hs_req:  if (ack_s2_ff) nxt_state = hs_rel;
      hs_rel:  if (!ack_s2_ff) nxt_state = hs_idle; // [RQ20]
      default: nxt_state = hs_idle;
    endcase
    nxt_req = (nxt_state == hs_req); // request leaves from its own flop
  end

  // ack passes two flops before use
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff  <= hs_idle;
      kind_ff   <= bus_read;
      req_ff    <= 1'h0;
      ack_s1_ff <= 1'h0;
      ack_s2_ff <= 1'h0;
    end else begin
      state_ff  <= nxt_state;
      kind_ff   <= nxt_kind;
      req_ff    <= nxt_req;
      ack_s1_ff <= ack_i;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  assign idle_o = (state_ff == hs_idle);
  assign req_o  = req_ff;
  assign kind_o = kind_ff;
endmodule

// ### sim/mem_partner.sv
// mem_partner: external memory answering four-phase bus cycles
// assumes req holds until ack is seen; lat_i sets the answer delay
`timescale 1ns/1ps
module mem_partner (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // processor bus
  input  wire logic       req_i,
  input  wire logic [3:0] lat_i,
  output logic            ack_o
);
  int wait_cnt;
  // ack after lat_i cycles, held until req falls, then low
  always @(posedge mclk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 0;
    end else if (req_i && !ack_o) begin
      if (wait_cnt >= int'(lat_i))
        ack_o <= 1'b1;
      wait_cnt <= wait_cnt + 1;
    end else if (!req_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 0;
    end
  end
endmodule

// ### sim/testbench.sv
// testbench: timing engine against tabulated clock and bus counts
// assumes mem_partner answers every bus cycle of memory forms
`timescale 1ns/1ps
module testbench;
  import timing_pkg::*;
  typedef struct packed {
    form_t   f;
    speed_t  s;
    report_t e;
  } row_t;
  logic       mclk_i;
  logic       rst_i;
  issue_t     issue_i;
  logic       busy_o;
  logic       done_o;
  report_t    report_o;
  logic       bus_ack_i;
  logic       bus_req_o;
  bus_kind_t  bus_kind_o;
  logic [3:0] lat_i;
  int         err_total;
  int         samples_checked;
  int         cyc;
  int         cyc0;
  row_t       rows [23];
  op_timing_engine uut (.mclk_i(mclk_i), .rst_i(rst_i), .issue_i(issue_i), .busy_o(busy_o),
    .done_o(done_o), .report_o(report_o), .bus_ack_i(bus_ack_i), .bus_req_o(bus_req_o),
    .bus_kind_o(bus_kind_o));
  mem_partner mem (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(bus_req_o), .lat_i(lat_i),
    .ack_o(bus_ack_i));
  // clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // issue one form, count cycles and bus cycles until done
  task automatic run(input row_t r, input logic [5:0] amt);
    int  n_rd;
    int  n_pf;
    int  n_wr;
    logic prev;
    logic late;
    logic in_time;
    n_rd = 0;
    n_pf = 0;
    n_wr = 0;
    prev = 1'b0;
    late = 1'b0;
    cyc = 0;
    @(posedge mclk_i);
    issue_i <= '{1'b1, r.f, r.s, amt};
    @(posedge mclk_i);
    issue_i.valid <= 1'b0;
    while (cyc < 300) begin
      @(posedge mclk_i);
      cyc++;
      #1;
      if (bus_req_o === 1'b1 && !prev) begin
        if (bus_kind_o === bus_read) begin
          n_rd++;
          late = late | (n_pf + n_wr > 0);
        end
        if (bus_kind_o === bus_prefetch) begin
          n_pf++;
          late = late | (n_wr > 0);
        end
        if (bus_kind_o === bus_write)
          n_wr++;
      end
      prev = (bus_req_o === 1'b1);
      if (done_o === 1'b1)
        break;
    end
    if (cyc >= 300) begin
      chk("done timeout", 1, 0);
      test_done();
    end else begin
      in_time = (cyc == r.e.total) || (n_rd + n_pf + n_wr > 0 && cyc >= r.e.total);
      chk("report", 32'(report_o), 32'(r.e));
      chk("reads", n_rd, 32'(r.e.reads));
      chk("prefetch", n_pf, 32'(r.e.prefetch));
      chk("writes", n_wr, 32'(r.e.writes));
      chk("bus order", late, 0);
      chk("cycles", in_time, 1);
      chk("busy at done", busy_o, 0);
    end
  endtask
  // main sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    lat_i = 4'h0;
    issue_i = '0;
    rows = '{
      '{decimal_add_with_extend_mem, case_best, '{5'h0e, 2'h2, 1'h0, 1'h1, ea_none}},
      '{decimal_subtract_with_extend_mem, case_worst, '{5'h11, 2'h2, 1'h1, 1'h1, ea_none}},
      '{binary_add_with_extend_mem, case_cache, '{5'h0c, 2'h2, 1'h0, 1'h1, ea_none}},
      '{binary_subtract_with_extend_mem, case_worst, '{5'h0d, 2'h2, 1'h1, 1'h1, ea_none}},
      '{decimal_compress_mem, case_best, '{5'h0b, 2'h1, 1'h0, 1'h1, ea_none}},
      '{decimal_expand_mem, case_worst, '{5'h0d, 2'h1, 1'h1, 1'h1, ea_none}},
      '{decimal_add_with_extend_reg, case_worst, '{5'h05, 2'h0, 1'h1, 1'h0, ea_none}},
      '{operand_zeroing_mem, case_worst, '{5'h06, 2'h0, 1'h1, 1'h1, ea_calc}},
      '{condition_set_mem, case_best, '{5'h06, 2'h0, 1'h0, 1'h1, ea_calc}},
      '{test_then_set_operand_mem, case_worst, '{5'h0d, 2'h1, 1'h1, 1'h1, ea_calc}},
      '{logical_shift_rightward_dynamic, case_cache, '{5'h06, 2'h0, 1'h0, 1'h0, ea_none}},
      '{rotate_through_extend_leftward_reg, case_best, '{5'h09, 2'h0, 1'h0, 1'h0, ea_none}},
      '{rotate_rightward_mem, case_worst, '{5'h07, 2'h0, 1'h1, 1'h1, ea_fetch}},
      '{single_bit_clear_mem_imm, case_cache, '{5'h04, 2'h0, 1'h0, 1'h1, ea_fetch_imm}},
      '{single_bit_test_mem_reg, case_worst, '{5'h05, 2'h0, 1'h1, 1'h0, ea_fetch}},
      '{single_bit_set_reg, case_worst, '{5'h05, 2'h0, 1'h1, 1'h0, ea_none}},
      '{decimal_subtract_with_extend_mem, case_cache, '{5'h10, 2'h2, 1'h0, 1'h1, ea_none}},
      '{binary_add_with_extend_mem, case_worst, '{5'h0d, 2'h2, 1'h1, 1'h1, ea_none}},
      '{decimal_add_with_extend_reg, case_best, '{5'h04, 2'h0, 1'h0, 1'h0, ea_none}},
      '{logical_shift_rightward_dynamic, case_best, '{5'h03, 2'h0, 1'h0, 1'h0, ea_none}},
      '{rotate_through_extend_leftward_reg, case_cache, '{5'h0c, 2'h0, 1'h0, 1'h0, ea_none}},
      '{rotate_leftward_mem, case_best, '{5'h07, 2'h0, 1'h0, 1'h1, ea_fetch}},
      '{single_bit_set_mem_reg, case_cache, '{5'h04, 2'h0, 1'h0, 1'h1, ea_fetch}}};
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    chk("reset report", 32'(report_o), 0);
    chk("reset busy", 32'({busy_o, done_o, bus_req_o}), 0);
    $display("test reset done");
    foreach (rows[i])
      run(rows[i], 6'h01);
    $display("test table done");
    // same static shift at amounts 1 and 63 takes equal time
    run('{logical_shift_leftward_static, case_best, '{5'h01, 2'h0, 1'h0, 1'h0, ea_none}}, 6'h01);
    cyc0 = cyc;
    run('{logical_shift_leftward_static, case_best, '{5'h01, 2'h0, 1'h0, 1'h0, ea_none}}, 6'h3f);
    chk("shift cycles", cyc, cyc0);
    $display("test shift amount done");
    // slow memory stretches the run but not the counts
    lat_i = 4'h7;
    run(rows[9], 6'h00);
    chk("slow longer", cyc > 13, 1);
    $display("test slow memory done");
    // valid held three edges: refused while busy, taken again in the done cycle
    @(posedge mclk_i);
    issue_i <= '{1'b1, single_bit_toggle_reg, case_best, 6'h00};
    cyc = 0;
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk_i);
      if (k == 2)
        issue_i.valid <= 1'b0;
      #1;
      cyc = cyc + int'(done_o);
    end
    chk("back to back dones", cyc, 2);
    $display("test back to back done");
    test_done();
  end
endmodule
